// *** ppp_pkg.sv ***
// Constants and types for the parallel fuse programming port
//==========================================================
package ppp_pkg;
	//==========================================================
	// Fuse fields
	localparam logic [7:0] FUSE_LOW_RESET = 8'h61;   // 0110_0001
	localparam int FUSE_CLKDIV_BIT   = 7;
	localparam int FUSE_CLKOUT_BIT   = 6;
	localparam int FUSE_SUT_HI_BIT   = 5;
	localparam int FUSE_SUT_LO_BIT   = 4;
	localparam int FUSE_SLOWOSC_BIT  = 3;
	localparam int FUSE_FASTSEL_BIT  = 2;
	localparam int FUSE_BOD_BIT      = 1;
	localparam int FUSE_TEMPRST_BIT  = 0;
	localparam int FUSE_KEEP_BIT     = 3;            // In high fuse byte
	localparam logic [7:0] FUSE_HIGH_RESET = 8'hD9;
	localparam logic [7:0] MOTION_TRIM_RESET = 8'hFF;
	//==========================================================
	// Action select codes
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	//==========================================================
	// Command bytes
	localparam logic [7:0] CMD_CHIP_ERASE  = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE     = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK     = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH    = 8'h10;
	localparam logic [7:0] CMD_WR_EEPROM   = 8'h11;
	localparam logic [7:0] CMD_RD_SIG      = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE     = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH    = 8'h02;
	localparam logic [7:0] CMD_RD_EEPROM   = 8'h03;
	//==========================================================
	// Geometry
	localparam int FLASH_WORD_BITS  = 5;
	localparam int FLASH_PAGE_BITS  = 7;
	localparam int EE_BYTE_BITS     = 2;
	localparam int EE_PAGE_BITS     = 7;
	localparam int SIG_BYTES        = 3;
	//==========================================================
	// Timing
	localparam int CLOCK_HZ         = 25000000;
	localparam int PULSE_MIN_NS     = 1000;
	localparam int PULSE_MIN_CYC    = (PULSE_MIN_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
	localparam int BUSY_CYC_DEFAULT = 64;
	typedef enum logic [1:0] {PPP_IDLE, PPP_BUSY} ppp_state_type;
endpackage

// *** ppp_port.sv ***
// Parallel fuse programming port, device side
`timescale 1ns/10ps
module ppp_port #(
	parameter int          BUSY_CYC = ppp_pkg::BUSY_CYC_DEFAULT,
	parameter logic [7:0]  SIG_BYTE0 = 8'hA5,  // Arbitrary identity value
	parameter logic [7:0]  SIG_BYTE1 = 8'h5A,  // Arbitrary identity value
	parameter logic [7:0]  SIG_BYTE2 = 8'h3C   // Arbitrary identity value
) (
	// Clock, reset, enable
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// Mode and stored values
	input  wire logic        prog_mode,
	input  wire logic [7:0]  fast_trim_store,
	input  wire logic [7:0]  slow_trim_store,
	// Programming pins
	input  wire logic        load_strobe_pin,
	input  wire logic        action_select_lo,
	input  wire logic        action_select_hi,
	input  wire logic        byte_pick_first,
	input  wire logic        byte_pick_second,
	input  wire logic        page_latch_strobe,
	input  wire logic        write_n,
	input  wire logic        out_en_n,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	output logic             ready_busy_flag,
	// Memory side
	output logic      [7:0]  cmd_reg,
	output logic      [15:0] addr_reg,
	output logic      [15:0] data_reg,
	output logic      [ppp_pkg::FLASH_WORD_BITS-1:0] flash_word_index,
	output logic      [6:0]  flash_page_index,
	output logic      [8:0]  eeprom_byte_address,
	output logic             page_latch_pulse,
	output logic             op_start_pulse,
	output logic      [7:0]  op_cmd,
	input  wire logic [7:0]  mem_read_data,
	// Fuse outcomes
	output logic             clk_div8_en,
	output logic             clk_out_en,
	output logic      [1:0]  startup_sel,
	output logic             slow_osc_en,
	output logic             fast_osc_4mhz,
	output logic             brown_out_en,
	output logic             temp_reset_en,
	output logic             eeprom_keep_fuse,
	output logic      [7:0]  fast_osc_trim,
	output logic      [7:0]  slow_osc_trim,
	output logic      [7:0]  motion_sensor_trim
);
	//==========================================================
	// Local constants
	// The pulse floor is counted in clock cycles, so a faster clock
	// raises the count; the qualification counters saturate at 255
	localparam int FLASH_W = ppp_pkg::FLASH_WORD_BITS;  // Word-in-page field width
	localparam int MIN_C   = ppp_pkg::PULSE_MIN_CYC;    // Shortest accepted pulse, cycles

	//==========================================================
	// Elaboration checks
	// The busy counter is 16 bits wide and must run at least one cycle
	if (BUSY_CYC < 1 || BUSY_CYC > 65535) begin : busy_cyc_check
		$error("BUSY_CYC out of range");
	end
	// The pulse counters are 8 bits wide
	if (ppp_pkg::PULSE_MIN_CYC > 255) begin : pulse_min_check
		$error("PULSE_MIN_CYC out of range");
	end

	//==========================================================
	// Pin synchronisers
	// Every pin is asynchronous to this clock, so two flops stand
	// before any logic reads it; the two cycles of latency are small
	// against the pulse floor
	logic [9:0] sync1_reg;          // First stage, only read by second
	logic [9:0] sync2_reg;          // Second stage
	logic [9:0] prev_reg;           // For edge detection
	logic [7:0] din1_reg;
	logic [7:0] din_reg;
	logic       mode1_reg;
	logic       mode_reg;
	logic       mode_prev_reg;

	// Two flops on every pin
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			// Idle levels: strobes low, write and enable high
			sync1_reg <= 10'h380;
			sync2_reg <= 10'h380;
			din1_reg  <= 8'h00;
			din_reg   <= 8'h00;
			mode1_reg <= 1'b0;
			mode_reg  <= 1'b0;
		end else if (clk_en) begin
			// Bit 9 and bit 0 are fixed fillers
			sync1_reg <= {1'b1, out_en_n, write_n, page_latch_strobe, byte_pick_second,
				byte_pick_first, action_select_hi, action_select_lo, load_strobe_pin, 1'b0};
			sync2_reg <= sync1_reg;
			din1_reg  <= data_in;
			din_reg   <= din1_reg;
			mode1_reg <= prog_mode;
			mode_reg  <= mode1_reg;
		end
	end

	// Synchronised pin views
	logic s_load, s_xa0, s_xa1, s_bs1, s_bs2, s_page_latch_strobe, s_wr_n, s_oe_n;
	assign s_load  = sync2_reg[1];
	assign s_xa0   = sync2_reg[2];
	assign s_xa1   = sync2_reg[3];
	assign s_bs1   = sync2_reg[4];
	assign s_bs2   = sync2_reg[5];
	assign s_page_latch_strobe = sync2_reg[6];
	assign s_wr_n  = sync2_reg[7];
	assign s_oe_n  = sync2_reg[8];

	// Edge history
	// Reset to idle levels so no false edge follows reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg      <= 10'h380;
			mode_prev_reg <= 1'b0;
		end else if (clk_en) begin
			prev_reg      <= sync2_reg;
			mode_prev_reg <= mode_reg;
		end
	end

	//==========================================================
	// Pulse width qualification: pulses shorter than MIN_C are ignored
	// Counters saturate rather than wrap, so a very long pulse
	// still qualifies
	logic [7:0] load_hi_cnt, pl_hi_cnt, wr_lo_cnt;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			load_hi_cnt <= 8'h00;
			pl_hi_cnt   <= 8'h00;
			wr_lo_cnt   <= 8'h00;
		end else if (clk_en) begin
			load_hi_cnt <= s_load  ? ((load_hi_cnt == 8'hFF) ? load_hi_cnt : load_hi_cnt + 8'h01) : 8'h00;
			pl_hi_cnt   <= s_page_latch_strobe ? ((pl_hi_cnt == 8'hFF) ? pl_hi_cnt : pl_hi_cnt + 8'h01) : 8'h00;
			wr_lo_cnt   <= !s_wr_n ? ((wr_lo_cnt == 8'hFF) ? wr_lo_cnt : wr_lo_cnt + 8'h01) : 8'h00;
		end
	end

	logic load_evt, page_latch_strobe_evt, wr_evt, oe_fall;
	// Event at end of a qualified pulse
	// Acting on the trailing edge means data and selects have been
	// stable for the whole pulse when they are sampled
	// Output enable acts on its leading edge: the read must be
	// ready before the programmer samples the bus
	assign load_evt  = mode_reg && !s_load && prev_reg[1] && (load_hi_cnt >= 8'(MIN_C));
	assign page_latch_strobe_evt = mode_reg && !s_page_latch_strobe && prev_reg[6] && (pl_hi_cnt >= 8'(MIN_C));
	assign wr_evt    = mode_reg && s_wr_n && !prev_reg[7] && (wr_lo_cnt >= 8'(MIN_C));
	assign oe_fall   = mode_reg && !s_oe_n && prev_reg[8];

	//==========================================================
	// Busy state machine
	// A write starts a fixed busy stretch of BUSY_CYC cycles; array
	// timing is represented only by this count
	ppp_pkg::ppp_state_type state_reg;
	logic [15:0]            busy_cnt_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= ppp_pkg::PPP_IDLE;
			busy_cnt_reg <= 16'h0000;
		end else if (clk_en) begin
			case (state_reg)
				ppp_pkg::PPP_IDLE: begin
					if (wr_evt) begin
						state_reg    <= ppp_pkg::PPP_BUSY;
						busy_cnt_reg <= 16'(BUSY_CYC - 1);
					end
				end
				ppp_pkg::PPP_BUSY: begin
					if (busy_cnt_reg == 16'h0000)
						state_reg <= ppp_pkg::PPP_IDLE;
					else
						busy_cnt_reg <= busy_cnt_reg - 16'h0001;
				end
				default: state_reg <= ppp_pkg::PPP_IDLE;
			endcase
		end
	end
	// Low while busy
	// Combinational so the flag falls with the start pulse
	assign ready_busy_flag = (state_reg == ppp_pkg::PPP_IDLE);
	logic busy;
	assign busy = (state_reg == ppp_pkg::PPP_BUSY); // strobes while busy are dropped

	//==========================================================
	// Command, address and data loading
	// Loaded values are retained until overwritten, so one command
	// serves many addresses; loads while busy are dropped
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmd_reg  <= 8'h00;
			addr_reg <= 16'h0000;
			data_reg <= 16'h0000;
		end else if (clk_en && load_evt && !busy) begin
			case ({s_xa1, s_xa0})
				ppp_pkg::ACT_ADDR: begin
					if (s_bs1) addr_reg[15:8] <= din_reg;
					else       addr_reg[7:0]  <= din_reg;
				end
				ppp_pkg::ACT_DATA: begin
					if (s_bs1) data_reg[15:8] <= din_reg;
					else       data_reg[7:0]  <= din_reg;
				end
				ppp_pkg::ACT_CMD:  cmd_reg <= din_reg;
				// Idle code leaves every register untouched
				ppp_pkg::ACT_IDLE: cmd_reg <= cmd_reg;
				default:           cmd_reg <= cmd_reg;
			endcase
		end
	end

	// Page geometry from the loaded address
	// Address bits above each field are ignored here
	assign flash_word_index    = addr_reg[FLASH_W-1:0];
	assign flash_page_index    = addr_reg[11:5];
	assign eeprom_byte_address = addr_reg[8:0];

	//==========================================================
	// Strobes toward memory, registered one-cycle pulses
	// Registered so the memory side sees clean single pulses
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			page_latch_pulse <= 1'b0;
			op_start_pulse   <= 1'b0;
			op_cmd           <= 8'h00;
		end else if (clk_en) begin
			page_latch_pulse <= page_latch_strobe_evt && !busy;
			op_start_pulse   <= wr_evt && !busy;
			op_cmd           <= (wr_evt && !busy) ? cmd_reg : op_cmd;
		end
	end

	//==========================================================
	// Fuse store and latching
	// The live image takes writes at once; the outcome outputs other
	// than eeprom_keep_fuse follow only the latched copy, so a low fuse
	// write in programming mode changes nothing until the mode is left
	logic [7:0] fuse_low_reg;         // Programmed image, live
	logic [7:0] fuse_high_reg;
	logic [7:0] fuse_act_reg;         // Effective latched copy
	logic       wr_fuse;
	assign wr_fuse = wr_evt && !busy && (cmd_reg == ppp_pkg::CMD_WR_FUSE);

	// Write fuse bytes: low with BS1=0, high with BS1=1
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fuse_low_reg  <= ppp_pkg::FUSE_LOW_RESET;
			fuse_high_reg <= ppp_pkg::FUSE_HIGH_RESET;
		end else if (clk_en && wr_fuse && !s_bs2) begin
			if (s_bs1) fuse_high_reg <= data_reg[7:0];
			else       fuse_low_reg  <= data_reg[7:0];
		end
	end

	// Latch at power-up and at mode entry; held during programming
	// Exit reloads the copy too, which makes new values live
	logic latched_once_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fuse_act_reg     <= ppp_pkg::FUSE_LOW_RESET;
			latched_once_reg <= 1'b0;
		end else if (clk_en) begin
			latched_once_reg <= 1'b1;
			if (!latched_once_reg || (mode_reg && !mode_prev_reg) || (!mode_reg && mode_prev_reg))
				fuse_act_reg <= fuse_low_reg;
		end
	end

	// Programmed means zero
	// Most outcomes are active when their bit is programmed
	assign clk_div8_en   = !fuse_act_reg[ppp_pkg::FUSE_CLKDIV_BIT];
	assign clk_out_en    = !fuse_act_reg[ppp_pkg::FUSE_CLKOUT_BIT];
	assign startup_sel   = {fuse_act_reg[ppp_pkg::FUSE_SUT_HI_BIT],
		fuse_act_reg[ppp_pkg::FUSE_SUT_LO_BIT]};
	assign slow_osc_en   = !fuse_act_reg[ppp_pkg::FUSE_SLOWOSC_BIT];
	assign fast_osc_4mhz = !fuse_act_reg[ppp_pkg::FUSE_FASTSEL_BIT];
	assign brown_out_en  = !fuse_act_reg[ppp_pkg::FUSE_BOD_BIT];
	assign temp_reset_en = fuse_act_reg[ppp_pkg::FUSE_TEMPRST_BIT];
	// Not latched: acts as soon as written
	assign eeprom_keep_fuse = !fuse_high_reg[ppp_pkg::FUSE_KEEP_BIT];

	//==========================================================
	// Calibration load after reset
	// Trims are copied on the first enabled edge after reset;
	// the motion trim keeps its uncalibrated value
	logic cal_done_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fast_osc_trim      <= 8'h00;
			slow_osc_trim      <= 8'h00;
			motion_sensor_trim <= ppp_pkg::MOTION_TRIM_RESET;
			cal_done_reg       <= 1'b0;
		end else if (clk_en && !cal_done_reg) begin
			fast_osc_trim <= fast_trim_store;
			slow_osc_trim <= slow_trim_store;
			cal_done_reg  <= 1'b1;
		end
	end

	//==========================================================
	// Read path, launched on output enable fall
	// Signature bytes ignore any lock state; unknown commands read
	// back as all ones
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = mem_read_data;
		case (cmd_reg)
			ppp_pkg::CMD_RD_SIG: begin // no lock check
				case (addr_reg[1:0])
					2'h0:    rd_mux = SIG_BYTE0;
					2'h1:    rd_mux = SIG_BYTE1;
					2'h2:    rd_mux = SIG_BYTE2;
					default: rd_mux = 8'hFF;
				endcase
			end
			ppp_pkg::CMD_RD_FUSE: rd_mux = s_bs1 ? fuse_high_reg : fuse_low_reg;
			ppp_pkg::CMD_RD_FLASH: rd_mux = mem_read_data;
			ppp_pkg::CMD_RD_EEPROM: rd_mux = mem_read_data;
			default: rd_mux = 8'hFF;
		endcase
	end

	// Captured once per enable fall so the bus holds steady
	// while the programmer samples it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= 8'h00;
			data_oe  <= 1'b0;
		end else if (clk_en) begin
			if (oe_fall) data_out <= rd_mux;
			// Released whenever enable is high or the mode is off
			data_oe <= mode_reg && !s_oe_n;
		end
	end
endmodule

// *** ppp_port_monitor.sv ***
// Checker of the programming port outputs
`timescale 1ns/10ps
module ppp_port_monitor #(
	parameter int BUSY_CYC = 4
) (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// Pins
	input wire logic        prog_mode,
	input wire logic        out_en_n,
	input wire logic        data_oe,
	input wire logic        ready_busy_flag,
	// Memory side
	input wire logic [15:0] addr_reg,
	input wire logic [6:0]  flash_page_index,
	input wire logic [8:0]  eeprom_byte_address,
	input wire logic        page_latch_pulse,
	input wire logic        op_start_pulse,
	input wire logic [7:0]  op_cmd,
	input wire logic [7:0]  cmd_reg,
	// Fuse outcomes
	input wire logic        clk_div8_en,
	input wire logic        clk_out_en,
	input wire logic [1:0]  startup_sel,
	input wire logic        slow_osc_en,
	input wire logic        fast_osc_4mhz,
	input wire logic        brown_out_en,
	input wire logic        temp_reset_en,
	input wire logic [7:0]  motion_sensor_trim
);
	//==========================================================
	// Helpers
	wire [7:0] fz = {clk_div8_en, clk_out_en, startup_sel, slow_osc_en, fast_osc_4mhz, brown_out_en, temp_reset_en};
	int busy_cnt; // Low cycles of the ready flag
	// Count busy length, cleared while ready
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt <= 0;
		end else if (ready_busy_flag) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Operation launch and long output-enable stretches
	sequence s_start;
		op_start_pulse && !ready_busy_flag;
	endsequence
	sequence s_oe_low;
		(prog_mode && !out_en_n)[*5];
	endsequence
	//==========================================================
	// Assertions
	a_start_goes_busy: assert property (op_start_pulse |-> s_start) else $error("ready high at start");
	a_busy_length: assert property ($rose(ready_busy_flag) |-> busy_cnt == BUSY_CYC) else $error("busy length");
	a_op_cmd_match: assert property (op_start_pulse |-> op_cmd == cmd_reg) else $error("op command");
	a_oe_drives_bus: assert property (s_oe_low |-> data_oe) else $error("bus not driven");
	a_bus_released: assert property (out_en_n[*5] |-> !data_oe) else $error("bus not released");
	a_fuse_held: assert property (prog_mode && $past(prog_mode, 6) |-> $stable(fz)) else $error("fuse moved");
	a_motion_trim: assert property (motion_sensor_trim == 8'hFF) else $error("motion trim");
	a_page_slices: assert property (flash_page_index == addr_reg[11:5] && eeprom_byte_address == addr_reg[8:0])
		else $error("page slices");
	a_latch_single: assert property (page_latch_pulse |=> !page_latch_pulse) else $error("latch pulse");
	a_no_op_outside: assert property (!prog_mode && !$past(prog_mode, 8) |-> !op_start_pulse) else $error("op outside");
endmodule
bind ppp_port ppp_port_monitor #(.BUSY_CYC(BUSY_CYC)) mon_u (.clock, .rst_n, .prog_mode, .out_en_n, .data_oe,
	.ready_busy_flag, .addr_reg, .flash_page_index, .eeprom_byte_address, .page_latch_pulse, .op_start_pulse,
	.op_cmd, .cmd_reg, .clk_div8_en, .clk_out_en, .startup_sel, .slow_osc_en, .fast_osc_4mhz, .brown_out_en,
	.temp_reset_en, .motion_sensor_trim);

// *** ppp_programmer.sv ***
// Behavioural high-voltage programmer driving the port pins
`timescale 1ns/10ps
module ppp_programmer #(
	parameter int W = 26 // Pulse width, just over 1us
) (
	// Clock and device pins
	input wire logic       clock,
	input wire logic       ready_busy_flag,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	output logic           load_strobe_pin,
	output logic           action_select_lo,
	output logic           action_select_hi,
	output logic           byte_pick_first,
	output logic           byte_pick_second,
	output logic           page_latch_strobe,
	output logic           write_n,
	output logic           out_en_n,
	output logic [7:0]     data_in
);
	logic [7:0] drv; // Last value put on the bus
	// Undriven bus with enable low shows the inverse, never a stale copy
	assign data_in = data_oe ? data_out : (out_en_n ? drv : ~drv);
	// Selects and strobes zero, write and enable high at entry
	initial begin
		{load_strobe_pin, action_select_lo, action_select_hi, byte_pick_first} = 4'h0;
		{byte_pick_second, page_latch_strobe, write_n, out_en_n} = 4'h3;
		drv = 8'h00;
	end
	// Wait for ready, bounded
	task automatic rdy();
		int n;
		n = 0;
		while (ready_busy_flag !== 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
		end
	endtask
	// Load one byte with a strobe pulse
	task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
		rdy();
		{action_select_hi, action_select_lo} = act;
		byte_pick_first = bs1;
		drv = d;
		repeat (2) @(negedge clock);
		load_strobe_pin = 1'b1;
		repeat (W) @(negedge clock);
		load_strobe_pin = 1'b0;
		repeat (8) @(negedge clock);
	endtask
	// Low write pulse
	task automatic write(input logic bs1);
		rdy();
		byte_pick_first = bs1;
		repeat (2) @(negedge clock);
		write_n = 1'b0;
		repeat (W) @(negedge clock);
		write_n = 1'b1;
		repeat (8) @(negedge clock);
	endtask
	// Page latch pulse
	task automatic page();
		rdy();
		page_latch_strobe = 1'b1;
		repeat (W) @(negedge clock);
		page_latch_strobe = 1'b0;
		repeat (8) @(negedge clock);
	endtask
	// Output enable pulse, sample before release
	task automatic read(output logic [7:0] d);
		out_en_n = 1'b0;
		repeat (W) @(negedge clock);
		d = data_in;
		out_en_n = 1'b1;
		repeat (8) @(negedge clock);
	endtask
endmodule

// *** ppp_port_test.sv ***
// Self-checking bench of the programming port
`timescale 1ns/10ps
module ppp_port_test;
	localparam logic [7:0] SIG0 = 8'h4B; // Arbitrary identity value
	localparam logic [7:0] SIG1 = 8'hC3; // Arbitrary identity value
	localparam logic [7:0] SIG2 = 8'h1D; // Arbitrary identity value
	localparam logic [7:0] FDEF = 8'h61; // Low fuse as shipped
	logic clock, rst_n, prog_mode;
	logic [7:0] fst, sst, mrd, d;
	int mismatches, checks, cyc, n_pg, n_op;
	logic [7:0] last_op, cmd_reg, op_cmd, data_out, data_in, ft, st, mt;
	logic [15:0] addr_reg, data_reg;
	logic [6:0] pg_idx;
	logic [8:0] ee_adr;
	logic [1:0] sut;
	logic [4:0] fw_idx;
	logic oe, rdy, lsp, asl, ash, bp1, bp2, pls, wr_n, oe_n, pl_p, op_p, seen_busy;
	logic dv8, cko, sl, f4, bod, tmp, keep;
	wire [7:0] fo = {dv8, cko, sut, sl, f4, bod, tmp};
	ppp_port #(.BUSY_CYC(4), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) dut_u (.clock, .rst_n,
		.clk_en(1'b1), .prog_mode, .fast_trim_store(fst), .slow_trim_store(sst), .load_strobe_pin(lsp),
		.action_select_lo(asl), .action_select_hi(ash), .byte_pick_first(bp1), .byte_pick_second(bp2),
		.page_latch_strobe(pls), .write_n(wr_n), .out_en_n(oe_n), .data_in, .data_out, .data_oe(oe),
		.ready_busy_flag(rdy), .cmd_reg, .addr_reg, .data_reg, .flash_word_index(fw_idx), .flash_page_index(pg_idx),
		.eeprom_byte_address(ee_adr), .page_latch_pulse(pl_p), .op_start_pulse(op_p), .op_cmd,
		.mem_read_data(mrd), .clk_div8_en(dv8), .clk_out_en(cko), .startup_sel(sut), .slow_osc_en(sl),
		.fast_osc_4mhz(f4), .brown_out_en(bod), .temp_reset_en(tmp), .eeprom_keep_fuse(keep),
		.fast_osc_trim(ft), .slow_osc_trim(st), .motion_sensor_trim(mt));
	ppp_programmer pp_u (.clock, .ready_busy_flag(rdy), .data_out, .data_oe(oe), .load_strobe_pin(lsp),
		.action_select_lo(asl), .action_select_hi(ash), .byte_pick_first(bp1), .byte_pick_second(bp2),
		.page_latch_strobe(pls), .write_n(wr_n), .out_en_n(oe_n), .data_in);
	//==========================================================
	// Clock, pulse counters, hang guard
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (pl_p === 1'b1) n_pg++;
		if (op_p === 1'b1) begin
			n_op++;
			last_op = op_cmd;
		end
		if (rdy === 1'b0) seen_busy = 1'b1;
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	//==========================================================
	// Compare, verdict, expected fuse outputs
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Zero bit means programmed, i.e. feature active, except bits 5:4 and 0
	function automatic logic [7:0] fz(input logic [7:0] f);
		return {~f[7], ~f[6], f[5:4], ~f[3], ~f[2], ~f[1], f[0]};
	endfunction
	//==========================================================
	// Scenarios
	task automatic t_reset();
		chk(fo, fz(FDEF));
		chk({ft, st, mt}, {fst, sst, 8'hFF});
		chk({rdy, keep}, 2'h2);
	endtask
	task automatic t_load();
		pp_u.load(2'h2, 1'b0, 8'h10);
		chk(cmd_reg, 8'h10);
		pp_u.load(2'h0, 1'b0, 8'hA5);
		pp_u.load(2'h0, 1'b1, 8'h0B);
		pp_u.load(2'h1, 1'b0, 8'h34);
		pp_u.load(2'h1, 1'b1, 8'h12);
		pp_u.load(2'h3, 1'b1, 8'hEE);
		chk({cmd_reg, addr_reg, data_reg}, {8'h10, 16'h0BA5, 16'h1234});
		chk({pg_idx, ee_adr}, {7'h5D, 9'h1A5});
		chk(fw_idx, 5'h05);
	endtask
	task automatic t_page_write();
		n_pg = 0;
		n_op = 0;
		seen_busy = 1'b0;
		pp_u.page();
		chk(n_pg, 1);
		pp_u.write(1'b0);
		chk({n_op[7:0], last_op, 7'h0, seen_busy}, {8'h1, 8'h10, 8'h1});
		pp_u.rdy();
		chk(rdy, 1'b1);
	endtask
	task automatic t_read();
		pp_u.load(2'h2, 1'b0, 8'h08);
		for (int i = 0; i < 3; i++) begin
			pp_u.load(2'h0, 1'b0, 8'(i));
			pp_u.read(d);
			chk(d, i == 0 ? SIG0 : i == 1 ? SIG1 : SIG2);
		end
		pp_u.load(2'h2, 1'b0, 8'h02);
		pp_u.read(d);
		chk({d, 7'h0, oe}, {mrd, 8'h0});
	endtask
	task automatic t_fuse();
		pp_u.load(2'h2, 1'b0, 8'h40);
		pp_u.load(2'h1, 1'b0, 8'h9E);
		pp_u.write(1'b0);
		chk(fo, fz(FDEF));
		pp_u.load(2'h1, 1'b0, 8'hD1);
		pp_u.write(1'b1);
		chk(keep, 1'b1);
		prog_mode = 1'b0;
		repeat (10) @(negedge clock);
		chk(fo, fz(8'h9E));
		pp_u.load(2'h2, 1'b0, 8'h80);
		chk(cmd_reg, 8'h40);
	endtask
	//==========================================================
	// Main sequence
	initial begin
		{rst_n, prog_mode, mismatches, checks, cyc} = '0;
		{fst, sst, mrd} = {8'h3A, 8'hC5, 8'h96};
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		t_reset();
		prog_mode = 1'b1;
		repeat (10) @(negedge clock);
		t_load();
		t_page_write();
		t_read();
		t_fuse();
		finish_test();
	end
endmodule
